// ---- pwm_sync_regs.svh ----
`ifndef PWM_SYNC_REGS_SVH
`define PWM_SYNC_REGS_SVH

// register byte offsets
`define SYNC_SETUP_ADDR 8'h00
`define FREQ_ADDR       8'h04
`define PHASE_ADDR      8'h08
`define GCFG_ADDR       8'h0c
`define MODE_ADDR       8'h10
`define STATUS_ADDR     8'h14

// field positions
`define SYNC_DRIVE_BIT  0
`define SYNC_IGNORE_BIT 1
`define RCFG_DIS_BIT    6
`define FCM_BIT         0
`define ILIM_LO         9
`define ILIM_HI         10
`define ST_LOCKED_BIT   0
`define ST_FCM_BIT      1
`define ST_OC_BIT       2
`define ST_PINF_BIT     3
`define ST_INIT_BIT     4
`define ST_MEAS_BIT     5

// reset values
`define SYNC_SETUP_RST  2'h0
`define FREQ_RST        8'h0a
`define PHASE_RST       8'h00
`define GCFG_RST        8'h00
`define MODE_RST        16'h0600

// timing
`define CLK_KHZ         10000
`define FREQ_STEP_KHZ   100
`define INIT_TIME_US    100
`define INIT_CYCLES     (`INIT_TIME_US * `CLK_KHZ / 1000)
`define LOSS_PERIODS    4

`endif

// ---- pwm_sync_pkg.sv ----
package pwm_sync_pkg;

  typedef enum logic {st_init, st_run} init_state_e;

  typedef struct packed {
    logic [7:0] cnt;
  } gen_state_s;

  typedef struct packed {
    init_state_e st;
    logic [11:0] icnt;
    logic [11:0] edges;
    logic        quiet;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        oc1;
    logic        oc2;
    logic        tl1;
    logic        tl2;
    logic        nv1;
    logic        nv2;
    logic [9:0]  gap;
    logic        locked;
    logic [1:0]  sync_setup;
    logic [7:0]  freq;
    logic [7:0]  phase;
    logic [7:0]  gcfg;
    logic [15:0] mode;
    logic        oc_f;
    logic        pin_f;
    logic        measured;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
    logic        ready;
    logic        sw0;
    logic        sw1;
    logic        sync_out;
    logic        sync_oe_n;
    logic        fcm;
    logic [1:0]  ilim;
  } ctl_state_s;

endpackage

// ---- pwm_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pwm_if;
  logic [7:0] period;
  logic [7:0] nom_half;
  logic [7:0] offset;
  logic       limited;
  logic       resync;
  logic [7:0] cnt;
  logic       sw0;
  logic       sw1;
  logic       sync_hi;
  modport ctrl (output period, nom_half, offset, limited, resync, input cnt, sw0, sw1, sync_hi);
  modport gen  (input period, nom_half, offset, limited, resync, output cnt, sw0, sw1, sync_hi);
endinterface
`default_nettype wire

// ---- pwm_phase_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwm_phase_gen (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // timing to and from the controller
  pwm_if.gen        p
);

  pwm_sync_pkg::gen_state_s s;
  pwm_sync_pkg::gen_state_s next_s;
  logic [7:0]               half;

  function automatic logic [7:0] add_mod(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= {1'b0, m})
      sum = sum - {1'b0, m};
    if (sum >= {1'b0, m})
      sum = sum - {1'b0, m};
    return sum[7:0];
  endfunction

  assign half = {1'b0, p.period[7:1]};

  always_comb begin
    next_s = s;
    // restart on sync edge
    if (p.resync) begin
      next_s.cnt = (p.offset == 8'h00) ? 8'h00 : p.period - p.offset;
    end else if (s.cnt >= p.period - 8'h01) begin
      next_s.cnt = 8'h00;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign p.cnt = s.cnt;
  assign p.sw0 = s.cnt < half;
  // second node half a cycle later
  // half cycle apart
  assign p.sw1 = add_mod(s.cnt, p.nom_half, p.period) < half;
  assign p.sync_hi = add_mod(s.cnt, p.offset, p.period) < half;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  anti_phase_a: assert property (!p.limited && !p.period[0] && s.cnt < p.period |-> p.sw1 == !p.sw0)
    else $error("switch nodes not half a cycle apart");

endmodule
`default_nettype wire

// ---- pwm_sync_clock_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_regs.svh"
// Overview of operation
// - lock switching to sync pin clock unless driving it or ignoring it
// - forced continuous mode whenever locked to an external clock
// - keep switching from internal oscillator when external clock disappears
// - sync setup bit 1 makes the device ignore the pin clock
// - sync setup bit 0 turns the sync pin into a clock output
// - driven clock runs at the switching frequency, halved with it under on-time limit
// - driven clock leads the first switch node by the phase offset
// - first switch node rising edge placed offset after rising sync edge
// - clock present through init: measure it, load frequency rounded to 100 kHz
// - after measurement phase offset becomes zero and forced continuous is set
// - stored global config bit 6 skips resistor pin reading
// - two switch nodes run half a cycle apart
// - on-time limit lowers actual frequency, half-cycle separation may break
// - pwm mode bits 10:9 select valley limit and sense gain
// - positive valley limit sets the output overcurrent fault bit
module pwm_sync_clock_control #(
  parameter int INIT_CYCLES  = `INIT_CYCLES,
  parameter int LOSS_PERIODS = `LOSS_PERIODS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // sync pin
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe_n,
  // power stage status and straps
  input  wire logic        ilim_pos_hit,
  input  wire logic        ton_limited,
  input  wire logic        nvm_rcfg_disable,
  // switching control
  output logic             first_switch_node,
  output logic             second_switch_node,
  output logic             forced_continuous,
  output logic      [1:0]  ilim_sel,
  output logic      [1:0]  sense_gain_sel,
  output logic             output_overcurrent_fault,
  output logic             clock_locked
);

  if (INIT_CYCLES < 16 || INIT_CYCLES > 4095) begin : g_bad_init
    $error("INIT_CYCLES out of range");
  end
  if (LOSS_PERIODS < 1 || LOSS_PERIODS > 4) begin : g_bad_loss
    $error("LOSS_PERIODS out of range");
  end

  pwm_sync_pkg::ctl_state_s s;
  pwm_sync_pkg::ctl_state_s next_s;
  pwm_if                    pi ();
  logic                     ext_rise;
  logic [9:0]               loss_lim;
  logic                     drive;
  logic                     ignore;

  function automatic logic [7:0] period_of(input logic [7:0] code, input logic lim);
    int c;
    int p;
    c = (code == 8'h00) ? 1 : int'(code);
    p = (`CLK_KHZ / `FREQ_STEP_KHZ) / c;
    if (p < 2)
      p = 2;
    if (lim)
      p = p * 2;
    if (p > 255)
      p = 255;
    return 8'(p);
  endfunction

  function automatic logic [7:0] offset_of(input logic [7:0] ph, input logic [7:0] per);
    logic [15:0] prod;
    prod = {8'h00, ph} * {8'h00, per};
    return prod[15:8];
  endfunction

  assign drive    = s.sync_setup[`SYNC_DRIVE_BIT];
  assign ignore   = s.sync_setup[`SYNC_IGNORE_BIT];
  assign ext_rise = s.s2 & ~s.s3;
  assign loss_lim = 10'(LOSS_PERIODS * int'(period_of(s.freq, 1'b0)));

  assign pi.period   = period_of(s.freq, s.tl2);
  assign pi.nom_half = period_of(s.freq, 1'b0) >> 1;
  assign pi.limited  = s.tl2;
  assign pi.offset   = offset_of(s.phase, pi.period);
  assign pi.resync   = ext_rise & ~drive & ~ignore;

  pwm_phase_gen u_gen (
    .hclk    (hclk),
    .hresetn (hresetn),
    .p       (pi.gen)
  );

  always_comb begin
    int m;
    m = 0;
    next_s = s;
    next_s.s1  = sync_in;
    next_s.s2  = s.s1;
    next_s.s3  = s.s2;
    next_s.oc1 = ilim_pos_hit;
    next_s.oc2 = s.oc1;
    next_s.tl1 = ton_limited;
    next_s.tl2 = s.tl1;
    next_s.nv1 = nvm_rcfg_disable;
    next_s.nv2 = s.nv1;
    next_s.ready = 1'b1;

    // edge watchdog
    if (ext_rise)
      next_s.gap = 10'h000;
    else if (s.gap < loss_lim)
      next_s.gap = s.gap + 10'h001;

    if (drive || ignore)
      next_s.locked = 1'b0;
    else if (ext_rise)
      next_s.locked = 1'b1;
    else if (s.gap >= loss_lim)
      next_s.locked = 1'b0;

    // data phase write
    next_s.wr_pend = 1'b0;
    if (s.wr_pend) begin
      case (s.waddr)
        `SYNC_SETUP_ADDR: next_s.sync_setup = hwdata[1:0];
        `FREQ_ADDR:       next_s.freq = hwdata[7:0];
        `PHASE_ADDR:      next_s.phase = hwdata[7:0];
        `GCFG_ADDR:       next_s.gcfg[`RCFG_DIS_BIT] = hwdata[`RCFG_DIS_BIT];
        `MODE_ADDR:       next_s.mode = hwdata[15:0];
        `STATUS_ADDR: begin
          if (hwdata[`ST_OC_BIT])
            next_s.oc_f = 1'b0;
          if (hwdata[`ST_PINF_BIT])
            next_s.pin_f = 1'b0;
        end
        default: ;
      endcase
    end

    // address phase
    next_s.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.waddr   = haddr[7:0];
      end else begin
        case (haddr[7:0])
          `SYNC_SETUP_ADDR: next_s.rdata = {30'h0, s.sync_setup};
          `FREQ_ADDR:       next_s.rdata = {24'h0, s.freq};
          `PHASE_ADDR:      next_s.rdata = {24'h0, s.phase};
          `GCFG_ADDR:       next_s.rdata = {24'h0, s.gcfg};
          `MODE_ADDR:       next_s.rdata = {16'h0, s.mode};
          `STATUS_ADDR:     next_s.rdata = {26'h0, s.measured, s.st == pwm_sync_pkg::st_run,
                                            s.pin_f, s.oc_f, s.fcm, s.locked};
          default:          next_s.rdata = 32'h0000_0000;
        endcase
      end
    end

    if (s.oc2)
      next_s.oc_f = 1'b1;

    case (s.st)
      pwm_sync_pkg::st_init: begin
        next_s.icnt = s.icnt + 12'h001;
        if (s.icnt == 12'h002)
          next_s.gcfg[`RCFG_DIS_BIT] = s.nv2;
        if (ext_rise && s.edges != 12'hfff)
          next_s.edges = s.edges + 12'h001;
        if (s.gap >= loss_lim)
          next_s.quiet = 1'b1;
        if (s.icnt == 12'(INIT_CYCLES - 1)) begin
          next_s.st = pwm_sync_pkg::st_run;
          if (!s.gcfg[`RCFG_DIS_BIT] && s.edges != 12'h000) begin
            if (s.quiet) begin
              next_s.pin_f = 1'b1;
            end else begin
              m = (int'(s.edges) * (`CLK_KHZ / `FREQ_STEP_KHZ) + INIT_CYCLES / 2) / INIT_CYCLES;
              next_s.freq = 8'(m);
              next_s.phase = 8'h00;
              next_s.mode[`FCM_BIT] = 1'b1;
              next_s.measured = 1'b1;
            end
          end
        end
      end
      pwm_sync_pkg::st_run: ;
      default: next_s.st = pwm_sync_pkg::st_init;
    endcase

    // output flops
    next_s.sw0 = pi.sw0;
    next_s.sw1 = pi.sw1;
    next_s.sync_oe_n = ~drive;
    next_s.sync_out = drive & pi.sync_hi;
    next_s.fcm  = s.locked | s.mode[`FCM_BIT];
    next_s.ilim = s.mode[`ILIM_HI:`ILIM_LO];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s            <= '0;
      s.st         <= pwm_sync_pkg::st_init;
      s.sync_setup <= `SYNC_SETUP_RST;
      s.freq       <= `FREQ_RST;
      s.phase      <= `PHASE_RST;
      s.gcfg       <= `GCFG_RST;
      s.mode       <= `MODE_RST;
      s.ready      <= 1'b1;
      s.sync_oe_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata                   = s.rdata;
  assign hreadyout                = s.ready;
  assign hresp                    = s.oc_f & 1'b0;
  assign sync_out                 = s.sync_out;
  assign sync_oe_n                = s.sync_oe_n;
  assign first_switch_node        = s.sw0;
  assign second_switch_node       = s.sw1;
  assign forced_continuous        = s.fcm;
  assign ilim_sel                 = s.ilim;
  assign sense_gain_sel           = s.ilim;
  assign output_overcurrent_fault = s.oc_f;
  assign clock_locked             = s.locked;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ignore_no_lock_a: assert property (ignore |=> !s.locked)
    else $error("locked while ignoring the pin clock");
  lock_on_edge_a: assert property (ext_rise && !drive && !ignore |=> s.locked ##1 forced_continuous)
    else $error("no lock after sync edge");
  fcm_locked_a: assert property (s.locked |=> forced_continuous)
    else $error("locked without forced continuous");
  loss_unlock_a: assert property (s.locked && !ext_rise && s.gap >= loss_lim |=> !s.locked)
    else $error("clock loss not detected");
  keep_switch_a: assert property ($fell(s.locked) |-> ##[1:520] $rose(first_switch_node))
    else $error("switching stopped after clock loss");
  drive_pin_a: assert property (drive |=> !sync_oe_n)
    else $error("sync pin not driven");
  clk_lead_a: assert property ($rose(sync_out) && $stable(s.phase) && s.phase < 8'h80
                                |-> ##[0:130] $rose(first_switch_node))
    else $error("switch node not following driven clock");
  edge_place_a: assert property (pi.resync && pi.offset != 8'h00 |=> pi.cnt == $past(pi.period - pi.offset))
    else $error("switch node not placed from sync edge");
  meas_load_a: assert property (s.st == pwm_sync_pkg::st_init && s.icnt == 12'(INIT_CYCLES - 1) &&
                                !s.gcfg[`RCFG_DIS_BIT] && s.edges != 12'h000 && !s.quiet
                                |=> s.phase == 8'h00 && s.mode[`FCM_BIT] && s.measured)
    else $error("measurement did not load settings");
  rcfg_skip_a: assert property (s.st == pwm_sync_pkg::st_init && s.gcfg[`RCFG_DIS_BIT] && !s.measured
                                |=> !s.measured)
    else $error("measured while resistor pins disabled");
  lim_period_a: assert property (s.tl2 && s.freq >= 8'h02 |-> pi.period == 8'(2 * int'(period_of(s.freq, 1'b0))))
    else $error("frequency not lowered under on-time limit");
  ilim_sel_a: assert property ($past(hresetn) |-> ilim_sel == $past(s.mode[`ILIM_HI:`ILIM_LO]))
    else $error("limit select does not follow mode");
  oc_sticky_a: assert property (s.oc2 |=> output_overcurrent_fault)
    else $error("overcurrent fault not set");
  freq_round_a: assert property (s.measured && $rose(s.measured) |-> s.freq == 8'(($past(int'(s.edges))
                                 * 100 + INIT_CYCLES / 2) / INIT_CYCLES))
    else $error("measured frequency wrong");

  // pin ownership and lock
  release_pin_a: assert property (!drive |=> sync_oe_n)
    else $error("sync pin driven while output disabled");
  out_quiet_a: assert property (!drive |=> !sync_out)
    else $error("clock driven while output disabled");
  drive_no_lock_a: assert property (drive |=> !s.locked)
    else $error("locked while driving the sync pin");
  no_resync_a: assert property (drive || ignore |-> !pi.resync)
    else $error("pin clock used while driving or ignoring");
  lock_hold_a: assert property (s.locked && !drive && !ignore && s.gap < loss_lim |=> s.locked)
    else $error("lock dropped before the loss window");

  // internal timing
  count_step_a: assert property (!pi.resync && pi.cnt < pi.period - 8'h01 |=> pi.cnt == $past(pi.cnt) + 8'h01)
    else $error("switching counter stalled");
  count_wrap_a: assert property (!pi.resync && pi.cnt >= pi.period - 8'h01 |=> pi.cnt == 8'h00)
    else $error("switching period too long");
  node0_follow_a: assert property ($past(hresetn) |-> first_switch_node == $past(pi.sw0))
    else $error("first switch node not registered from counter");
  node1_follow_a: assert property ($past(hresetn) |-> second_switch_node == $past(pi.sw1))
    else $error("second switch node not registered from counter");

  // status and measurement
  oc_hold_a: assert property (s.oc_f && !(s.wr_pend && s.waddr == `STATUS_ADDR && hwdata[`ST_OC_BIT]) |=> s.oc_f)
    else $error("overcurrent fault lost without clear");
  gain_track_a: assert property ($past(hresetn) |-> sense_gain_sel == $past(s.mode[`ILIM_HI:`ILIM_LO]))
    else $error("sense gain does not follow mode");
  fcm_request_a: assert property (s.mode[`FCM_BIT] |=> forced_continuous)
    else $error("forced continuous request ignored");
  init_end_a: assert property (s.icnt == 12'(INIT_CYCLES - 1) |=> s.st == pwm_sync_pkg::st_run)
    else $error("init window did not end");
  init_count_a: assert property (s.st == pwm_sync_pkg::st_init |=> s.icnt == $past(s.icnt) + 12'h001)
    else $error("init window counter stalled");
  edge_count_a: assert property (s.st == pwm_sync_pkg::st_init && ext_rise && s.edges != 12'hfff
                                 |=> s.edges == $past(s.edges) + 12'h001)
    else $error("sync edge not counted during init");
  pin_fault_a: assert property (s.icnt == 12'(INIT_CYCLES - 1) && !s.gcfg[`RCFG_DIS_BIT] && s.edges != 12'h000
                                && s.quiet |=> s.pin_f)
    else $error("unsteady clock did not flag pin fault");
  strap_load_a: assert property (s.icnt == 12'h002 |=> s.gcfg[`RCFG_DIS_BIT] == $past(s.nv2))
    else $error("stored strap not loaded");

endmodule
`default_nettype wire

// ---- sync_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_source #(
  parameter int HALF_NS = 400
) (
  // control
  input  wire logic en,
  input  wire logic dev_oe_n,
  // shared sync line
  output logic      line,
  output logic      line_oe_n
);
  // drive only while the device leaves the line
  assign line_oe_n = !(en && dev_oe_n);
  // clock stands still low while disabled
  initial begin
    line = 1'b0;
    #37;
    forever begin
      #HALF_NS;
      line = en ? !line : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_regs.svh"
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
  localparam int INIT = 320;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        ilim_pos_hit;
  logic        ton_limited;
  logic        nvm_rcfg_disable;
  logic        src_en;
  wire  [31:0] hrdata;
  wire         hready;
  wire         sync_out;
  wire         sync_oe_n;
  wire         src_line;
  wire         src_oe_n;
  wire         sw0;
  wire         sw1;
  wire         fcm;
  wire  [1:0]  ilim_sel;
  wire  [1:0]  gain_sel;
  wire         oc_fault;
  wire         locked;
  wire         sync_line = !sync_oe_n ? sync_out : (!src_oe_n ? src_line : 1'b0);
  wire  [3:0]  mon = {sync_line, sync_out, sw1, sw0};
  int          failures = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seed = 64;
  logic [31:0] mdl [8];
  pwm_sync_clock_control #(.INIT_CYCLES(INIT), .LOSS_PERIODS(4)) u_pwm_sync_clock_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
    .sync_in(sync_line), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .ilim_pos_hit(ilim_pos_hit),
    .ton_limited(ton_limited), .nvm_rcfg_disable(nvm_rcfg_disable), .first_switch_node(sw0),
    .second_switch_node(sw1), .forced_continuous(fcm), .ilim_sel(ilim_sel), .sense_gain_sel(gain_sel),
    .output_overcurrent_fault(oc_fault), .clock_locked(locked));
  sync_source #(.HALF_NS(400)) u_sync_source (
    .en(src_en), .dev_oe_n(sync_oe_n), .line(src_line), .line_oe_n(src_oe_n));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? wd : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    if (w) mdl[a[4:2]] = wd;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  task automatic rd_cmp(input logic [7:0] a);
    logic [31:0] d;
    rd(a, d);
    `CHECK(d, mdl[a[4:2]])
  endtask
  task automatic wait_rise(input int b, output int t);
    logic p;
    int   n;
    p = 1'b1;
    for (n = 0; n < 600; n++) begin
      @(posedge hclk);
      if (mon[b] === 1'b1 && p === 1'b0) break;
      p = mon[b];
    end
    t = cyc;
  endtask
  task automatic gap(input int b0, input int b1, output int g);
    int t0;
    int t1;
    wait_rise(b0, t0);
    wait_rise(b1, t1);
    g = t1 - t0;
  endtask
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] r;
    logic [15:0] v;
    int          g;
    int          n;
    hresetn = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hwdata = 32'h0;
    ilim_pos_hit = 1'b0; ton_limited = 1'b0; nvm_rcfg_disable = 1'b0; src_en = 1'b1;
    mdl = '{32'h0, 32'h0a, 32'h0, 32'h0, 32'h600, 32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wr(`PHASE_ADDR, 32'h40);
    repeat (INIT + 20) @(posedge hclk);
    mdl[2] = 32'h0;
    mdl[4] = 32'h601;
    rd(`FREQ_ADDR, d);
    `CHECK(d == 12 || d == 13, 1'b1)
    rd_cmp(`PHASE_ADDR);
    rd_cmp(`MODE_ADDR);
    rd(`STATUS_ADDR, d);
    `CHECK(d[5:4], 2'b11)
    rd(8'h20, d);
    `CHECK(d, 32'h0)
    rd_cmp(`GCFG_ADDR);
    for (int c = 0; c < 4; c++) begin
      r = $random(seed);
      v = {r[15:11], c[1:0], r[8:1], 1'b0};
      wr(`MODE_ADDR, {16'h0, v});
      rd_cmp(`MODE_ADDR);
      `CHECK(ilim_sel, c[1:0])
      `CHECK(gain_sel, c[1:0])
    end
    // internal frequency near the external clock
    wr(`FREQ_ADDR, 32'h0a);
    rd_cmp(`FREQ_ADDR);
    repeat (30) @(posedge hclk);
    `CHECK(locked, 1'b1)
    `CHECK(fcm, 1'b1)
    gap(3, 0, g);
    `CHECK(g inside {[3:8]}, 1'b1)
    wr(`SYNC_SETUP_ADDR, 32'h2);
    repeat (20) @(posedge hclk);
    `CHECK(locked, 1'b0)
    `CHECK(fcm, 1'b0)
    gap(0, 0, g);
    `CHECK(g, 10)
    wr(`SYNC_SETUP_ADDR, 32'h0);
    for (n = 0; n < 60 && locked !== 1'b1; n++) @(posedge hclk);
    `CHECK(locked, 1'b1)
    src_en <= 1'b0;
    for (n = 0; n < 80 && locked !== 1'b0; n++) @(posedge hclk);
    `CHECK(n inside {[28:52]}, 1'b1)
    gap(0, 0, g);
    `CHECK(g, 10)
    wr(`PHASE_ADDR, 32'h40);
    wr(`SYNC_SETUP_ADDR, 32'h1);
    repeat (2) @(posedge hclk);
    `CHECK(sync_oe_n, 1'b0)
    gap(2, 2, g);
    `CHECK(g, 10)
    gap(2, 0, g);
    `CHECK(g, 64 * 10 / 256)
    gap(0, 1, g);
    `CHECK(g, 5)
    ton_limited <= 1'b1;
    repeat (30) @(posedge hclk);
    gap(0, 0, g);
    `CHECK(g, 20)
    ton_limited <= 1'b0;
    `CHECK(oc_fault, 1'b0)
    ilim_pos_hit <= 1'b1;
    @(posedge hclk);
    ilim_pos_hit <= 1'b0;
    repeat (5) @(posedge hclk);
    `CHECK(oc_fault, 1'b1)
    rd(`STATUS_ADDR, d);
    `CHECK(d[2], 1'b1)
    wr(`STATUS_ADDR, 32'h4);
    rd(`STATUS_ADDR, d);
    `CHECK(d[2], 1'b0)
    wr(`SYNC_SETUP_ADDR, 32'h0);
    src_en <= 1'b1;
    nvm_rcfg_disable <= 1'b1;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (INIT + 20) @(posedge hclk);
    mdl = '{32'h0, 32'h0a, 32'h0, 32'h40, 32'h600, 32'h0, 32'h0, 32'h0};
    rd_cmp(`FREQ_ADDR);
    rd_cmp(`GCFG_ADDR);
    rd(`STATUS_ADDR, d);
    `CHECK(d[5], 1'b0)
    summarize();
  end
endmodule
`default_nettype wire
